/* hdl/ipcc_card_config.sv */
// Plug and play card control registers behind the ISA configuration ports
`timescale 1ns/1ps
module ipcc_card_config import ipcc_pkg::*; #(
  parameter int SERIAL_BITS = 72,
  // Serial identifier, value arbitrary
  parameter logic [SERIAL_BITS-1:0] SERIAL_ID = 72'h5a_0000_1234_5678_9abc,
  parameter int RES_DEPTH = 16,
  // Resource bytes, byte 0 in the low bits
  parameter logic [8*RES_DEPTH-1:0] RESOURCE_DATA = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] sa,
  input wire logic iow_n,
  input wire logic ior_n,
  input wire logic [7:0] sd_in,
  output logic [7:0] sd_out,
  output logic sd_oe,
  output logic [3:0] card_state,
  output logic [7:0] card_select_number,
  output logic logical_reset
);
  localparam int PW = $clog2(RES_DEPTH);

  // Synchronised pins
  logic [11:0] sa_s;
  logic [7:0] sd_s;
  logic iow_s;
  logic ior_s;
  // Previous strobe levels for end-of-cycle detection
  logic iow_prev_q;
  logic ior_prev_q;
  // Card state and registers
  ipcc_state_t state_q;
  ipcc_state_t state_d;
  logic [7:0] index_q;
  logic [7:0] rd_loc_q;
  logic [7:0] csn_q;
  logic [7:0] key_q;
  logic [4:0] key_cnt_q;
  logic [6:0] iso_bit_q;
  logic iso_phase_q;
  logic iso_saw_q;
  logic [PW-1:0] res_ptr_q;
  logic ready_q;
  logic [7:0] res_mem [RES_DEPTH];

  // Address and data bus synchroniser
  ipcc_sync #(.W(20), .INIT(20'h0_0000)) bus_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({sa, sd_in}),
    .q({sa_s, sd_s})
  );

  // Strobe synchroniser, idle high
  ipcc_sync #(.W(2), .INIT(2'h3)) strobe_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({iow_n, ior_n}),
    .q({iow_s, ior_s})
  );

  // Resource bytes laid out as an array
  for (genvar i = 0; i < RES_DEPTH; i++) begin : g_res
    assign res_mem[i] = RESOURCE_DATA[8*i +: 8];
  end

  // Cycle ends at the rising edge of each strobe
  wire wr_done = iow_s & ~iow_prev_q;
  wire rd_done = ior_s & ~ior_prev_q;
  // Port decode
  wire [11:0] rd_port = {IPCC_RD_HIGH_BITS, rd_loc_q, IPCC_RD_LOW_BITS};
  wire hit_index = sa_s == IPCC_INDEX_PORT;
  wire hit_wdata = sa_s == IPCC_WDATA_PORT;
  wire hit_rdata = sa_s == rd_port;
  // Data ports stay closed until the key is seen
  wire data_open = state_q != IPCC_WAIT_KEY;
  wire rd_open = (state_q == IPCC_ISOLATE) || (state_q == IPCC_CONFIG);
  wire wr_index = wr_done & hit_index;
  wire wr_reg = wr_done & hit_wdata & data_open;
  wire rd_reg = rd_done & hit_rdata & rd_open;
  // Register write decode
  wire wr_cfg = wr_reg & (index_q == IPCC_IDX_CONFIG);
  wire cmd_reset = wr_cfg & sd_s[IPCC_CMD_RESET_BIT];
  wire cmd_wait_key = wr_cfg & sd_s[IPCC_CMD_WAIT_KEY_BIT];
  wire cmd_csn_clr = wr_cfg & sd_s[IPCC_CMD_CSN_CLR_BIT];
  wire wr_wake = wr_reg & (index_q == IPCC_IDX_WAKE);
  wire wake_match = wr_wake & (sd_s == csn_q);
  wire wr_loc = wr_reg & (index_q == IPCC_IDX_RD_PORT);
  wire wr_csn = wr_reg & (index_q == IPCC_IDX_CSN);
  // Register read decode
  wire rd_iso = rd_reg & (index_q == IPCC_IDX_ISOLATE) & (state_q == IPCC_ISOLATE);
  wire rd_res = rd_reg & (index_q == IPCC_IDX_RES_DATA);
  // Initiation key step, taken only at the index port
  wire key_hit = sd_s == key_q;
  wire [7:0] key_next = {key_q[1] ^ key_q[0], key_q[7:1]};
  wire key_done = wr_index & (state_q == IPCC_WAIT_KEY) & key_hit & (key_cnt_q == IPCC_KEY_LAST);
  // Isolation: own bit and losing a comparison
  wire own_bit = SERIAL_ID[iso_bit_q];
  wire iso_last = iso_bit_q == 7'(SERIAL_BITS - 1);
  wire iso_lose = rd_iso & iso_phase_q & ~own_bit & iso_saw_q & (sd_s == IPCC_ISO_SECOND);
  wire [7:0] iso_byte = iso_phase_q ? IPCC_ISO_SECOND : IPCC_ISO_FIRST;
  // A card whose bit is zero leaves the bus to others during isolation
  wire iso_quiet = (index_q == IPCC_IDX_ISOLATE) & (state_q == IPCC_ISOLATE) & ~own_bit;
  // Read data select; everything unlisted reads zero
  wire [7:0] rd_mux =
    (index_q == IPCC_IDX_ISOLATE && state_q == IPCC_ISOLATE) ? iso_byte :
    (index_q == IPCC_IDX_RES_DATA) ? res_mem[res_ptr_q] :
    (index_q == IPCC_IDX_STATUS) ? {7'h00, ready_q} :
    (index_q == IPCC_IDX_CSN) ? csn_q :
    (index_q == IPCC_IDX_LDEV) ? IPCC_ZERO_BYTE : IPCC_ZERO_BYTE;
  wire oe_d = ~ior_s & hit_rdata & rd_open & ~iso_quiet;

  // Next card state, wait-for-key command overrides every other transition
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IPCC_WAIT_KEY: begin
        if (key_done) begin
          state_d = IPCC_SLEEP;
        end
      end
      IPCC_SLEEP: begin
        if (wake_match) begin
          state_d = (sd_s == IPCC_ZERO_BYTE) ? IPCC_ISOLATE : IPCC_CONFIG;
        end
      end
      IPCC_ISOLATE: begin
        if ((wr_wake && !wake_match) || iso_lose) begin
          state_d = IPCC_SLEEP;
        end else if (wr_csn) begin
          state_d = IPCC_CONFIG;
        end
      end
      IPCC_CONFIG: begin
        if (wr_wake && !wake_match) begin
          state_d = IPCC_SLEEP;
        end
      end
    endcase
    if (cmd_wait_key) begin
      state_d = IPCC_WAIT_KEY;
    end
  end

  // State and strobe history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IPCC_WAIT_KEY;
      iow_prev_q <= 1'b1;
      ior_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      iow_prev_q <= iow_s;
      ior_prev_q <= ior_s;
    end
  end

  // Index register and read port location
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      index_q <= IPCC_INDEX_RESET;
      rd_loc_q <= IPCC_RD_LOC_RESET;
    end else begin
      if (wr_index && data_open) begin
        index_q <= sd_s;
      end
      if (wr_loc) begin
        rd_loc_q <= sd_s;
      end
    end
  end

  // Card select number: clear command, else host write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csn_q <= IPCC_CSN_RESET;
    end else if (cmd_csn_clr) begin
      csn_q <= IPCC_CSN_RESET;
    end else if (wr_csn) begin
      csn_q <= sd_s;
    end
  end

  // Initiation key sequencer, restarts on any mismatch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_q <= IPCC_KEY_SEED;
      key_cnt_q <= 5'h00;
    end else if (state_q != IPCC_WAIT_KEY) begin
      key_q <= IPCC_KEY_SEED;
      key_cnt_q <= 5'h00;
    end else if (wr_index) begin
      key_q <= key_hit ? key_next : IPCC_KEY_SEED;
      key_cnt_q <= key_hit ? key_cnt_q + 5'h01 : 5'h00;
    end
  end

  // Isolation bit walk, two reads per serial bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iso_bit_q <= 7'h00;
      iso_phase_q <= 1'b0;
      iso_saw_q <= 1'b0;
    end else if (state_q != IPCC_ISOLATE) begin
      iso_bit_q <= 7'h00;
      iso_phase_q <= 1'b0;
      iso_saw_q <= 1'b0;
    end else if (rd_iso) begin
      iso_phase_q <= ~iso_phase_q;
      iso_saw_q <= sd_s == IPCC_ISO_FIRST;
      if (iso_phase_q && !iso_last) begin
        iso_bit_q <= iso_bit_q + 7'h01;
      end
    end
  end

  // Resource pointer and ready flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res_ptr_q <= '0;
      ready_q <= 1'b0;
    end else if (cmd_reset || (state_q == IPCC_SLEEP && wake_match)) begin
      res_ptr_q <= '0;
      ready_q <= 1'b0;
    end else if (rd_res) begin
      res_ptr_q <= res_ptr_q + 1'b1;
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sd_out <= IPCC_ZERO_BYTE;
      sd_oe <= 1'b0;
      card_state <= IPCC_WAIT_KEY;
      card_select_number <= IPCC_CSN_RESET;
      logical_reset <= 1'b0;
    end else begin
      sd_out <= rd_mux;
      sd_oe <= oe_d;
      card_state <= state_d;
      card_select_number <= cmd_csn_clr ? IPCC_CSN_RESET : (wr_csn ? sd_s : csn_q);
      logical_reset <= cmd_reset;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  cfg_reset_a: assert property (cmd_reset && !cmd_csn_clr |=>
    logical_reset && card_select_number == $past(csn_q))
    else $error("reset command lost or card number changed");
  wait_key_a: assert property (cmd_wait_key |=> state_q == IPCC_WAIT_KEY &&
    csn_q == $past(csn_q))
    else $error("wait-for-key command not taken");
  csn_clear_a: assert property (cmd_csn_clr |=> csn_q == IPCC_CSN_RESET)
    else $error("card number not cleared");
  cmd_self_clear_a: assert property (logical_reset |=> !logical_reset)
    else $error("reset pulse did not clear itself");
  wake_move_a: assert property (state_q == IPCC_SLEEP && wake_match && !cmd_wait_key
    |=> state_q == (($past(sd_s) == IPCC_ZERO_BYTE) ? IPCC_ISOLATE : IPCC_CONFIG))
    else $error("wake did not move the card");
  res_step_a: assert property (rd_res && !cmd_reset |=>
    res_ptr_q == $past(res_ptr_q) + 1'b1)
    else $error("resource pointer did not step");
  ready_pulse_a: assert property (rd_res |=> !ready_q ##1 ready_q)
    else $error("ready flag wrong around a resource read");
  closed_bus_a: assert property (state_q == IPCC_WAIT_KEY |=> !sd_oe)
    else $error("bus driven before the key");
  rd_addr_a: assert property (sd_oe |-> $past(sa_s[1:0]) == IPCC_RD_LOW_BITS &&
    $past(sa_s[9:2]) == $past(rd_loc_q))
    else $error("read port driven at wrong address");
  index_hold_a: assert property (wr_reg |=> index_q == $past(index_q))
    else $error("index changed by a data access");
endmodule

/* hdl/ipcc_pkg.sv */
// Shared constants and types for the plug and play card configuration block
package ipcc_pkg;
  // Fixed host I/O ports of the configuration window
  localparam logic [11:0] IPCC_INDEX_PORT = 12'h279;
  localparam logic [11:0] IPCC_WDATA_PORT = 12'ha79;
  // Low two address bits of the relocatable read port
  localparam logic [1:0] IPCC_RD_LOW_BITS = 2'h3;
  // Upper address bits of the read port, always zero
  localparam logic [1:0] IPCC_RD_HIGH_BITS = 2'h0;
  // Card control register indices
  localparam logic [7:0] IPCC_IDX_RD_PORT = 8'h00;
  localparam logic [7:0] IPCC_IDX_ISOLATE = 8'h01;
  localparam logic [7:0] IPCC_IDX_CONFIG = 8'h02;
  localparam logic [7:0] IPCC_IDX_WAKE = 8'h03;
  localparam logic [7:0] IPCC_IDX_RES_DATA = 8'h04;
  localparam logic [7:0] IPCC_IDX_STATUS = 8'h05;
  localparam logic [7:0] IPCC_IDX_CSN = 8'h06;
  localparam logic [7:0] IPCC_IDX_LDEV = 8'h07;
  // Command bit positions inside the config command register
  localparam int IPCC_CMD_RESET_BIT = 0;
  localparam int IPCC_CMD_WAIT_KEY_BIT = 1;
  localparam int IPCC_CMD_CSN_CLR_BIT = 2;
  // Ready flag position in the status register
  localparam int IPCC_READY_BIT = 0;
  // Reset values
  localparam logic [7:0] IPCC_CSN_RESET = 8'h00;
  localparam logic [7:0] IPCC_INDEX_RESET = 8'h00;
  localparam logic [7:0] IPCC_RD_LOC_RESET = 8'h00;
  localparam logic [7:0] IPCC_ZERO_BYTE = 8'h00;
  // Initiation key sequencer: seed byte and last step of 32
  localparam logic [7:0] IPCC_KEY_SEED = 8'h6a;
  localparam logic [4:0] IPCC_KEY_LAST = 5'h1f;
  // Isolation answer bytes, first and second read of a bit
  localparam logic [7:0] IPCC_ISO_FIRST = 8'h55;
  localparam logic [7:0] IPCC_ISO_SECOND = 8'haa;
  // Card states
  typedef enum logic [3:0] {
    IPCC_WAIT_KEY = 4'b0001,
    IPCC_SLEEP = 4'b0010,
    IPCC_ISOLATE = 4'b0100,
    IPCC_CONFIG = 4'b1000
  } ipcc_state_t;
endpackage

/* hdl/ipcc_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ipcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second stage
  logic [W-1:0] meta_q;

  // Two stages, reset to the idle level of the pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* tb/ipcc_host_model.sv */
// Host side of the ISA configuration ports: I/O cycle tasks and bus level
`timescale 1ns/1ps
module ipcc_host_model (
  input wire logic clk,
  output logic [11:0] sa,
  output logic iow_n,
  output logic ior_n,
  output logic [7:0] sd_in,
  input wire logic [7:0] sd_out,
  input wire logic sd_oe
);
  logic drv; // Host drives the data lines
  logic [7:0] wdat; // Write data held on the lines
  logic [7:0] other; // Byte another card puts on the lines, ff when none does
  // Card wins while enabled, else host, else another card or the pull-ups
  assign sd_in = sd_oe ? sd_out : (drv ? wdat : other);
  // Idle bus from time zero
  initial begin
    sa = 12'h000;
    iow_n = 1'b1;
    ior_n = 1'b1;
    drv = 1'b0;
    wdat = 8'h00;
    other = 8'hff;
  end
  // Another card answering isolation reads beside this one
  task automatic set_other(input logic [7:0] b);
    other = b;
  endtask
  // Wait some rising edges, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Write cycle: address and data settle before and hold past the strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    sa = a;
    wdat = d;
    drv = 1'b1;
    tick(3);
    iow_n = 1'b0;
    tick(4);
    iow_n = 1'b1;
    tick(1);
    drv = 1'b0;
    sa = 12'h000;
    tick(3);
  endtask
  // Read cycle: data taken at the edge the strobe is released after
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    sa = a;
    tick(3);
    ior_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    d = sd_in;
    ior_n = 1'b1;
    tick(1);
    sa = 12'h000;
    tick(3);
  endtask
endmodule

/* tb/ipcc_card_config_bench.sv */
// Self-checking bench for the plug and play card configuration block
`timescale 1ns/1ps
module ipcc_card_config_bench import ipcc_pkg::*;;
  localparam logic [71:0] SER = 72'h00_0000_0000_0000_00a5; // Arbitrary serial id
  localparam logic [31:0] RES = 32'h4433_2211; // Resource bytes
  logic clk;
  logic reset_n;
  logic [11:0] sa;
  logic iow_n;
  logic ior_n;
  logic [7:0] sd_in;
  logic [7:0] sd_out;
  logic sd_oe;
  logic [3:0] card_state;
  logic [7:0] card_select_number;
  logic logical_reset;
  logic [11:0] rport; // Current read port address
  logic [7:0] v;
  logic [7:0] key;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  int pulses = 0;
  int p0;
  ipcc_card_config #(.SERIAL_ID(SER), .RES_DEPTH(4), .RESOURCE_DATA(RES)) dut_u (
    .clk(clk), .reset_n(reset_n), .sa(sa), .iow_n(iow_n), .ior_n(ior_n),
    .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .card_state(card_state),
    .card_select_number(card_select_number), .logical_reset(logical_reset));
  ipcc_host_model host_u (.clk(clk), .sa(sa), .iow_n(iow_n), .ior_n(ior_n),
    .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe));
  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cycle limit and count of device reset pulses
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (logical_reset === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // Compare one value and report a mismatch
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Register write and read through the index port
  task automatic rw(input logic [7:0] idx, input logic [7:0] d);
    host_u.wr(IPCC_INDEX_PORT, idx);
    host_u.wr(IPCC_WDATA_PORT, d);
  endtask
  task automatic rr(input logic [7:0] idx, output logic [7:0] d);
    host_u.wr(IPCC_INDEX_PORT, idx);
    host_u.rd(rport, d);
  endtask
  // Poll the ready flag, then fetch one resource byte
  task automatic rd_res(output logic [7:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 8 && s[0] !== 1'b1; n++) rr(IPCC_IDX_STATUS, s);
    chk("status", 8'h01, s);
    rr(IPCC_IDX_RES_DATA, d);
  endtask
  // Initiation key: 32 bytes from the seed
  task automatic send_key();
    key = IPCC_KEY_SEED;
    repeat (32) begin
      host_u.wr(IPCC_INDEX_PORT, key);
      key = {key[1] ^ key[0], key[7:1]};
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    rport = 12'h003;
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    host_u.tick(1);
    chk("state", {4'h0, IPCC_WAIT_KEY}, {4'h0, card_state});
    rw(IPCC_IDX_CSN, 8'h05);
    chk("csn", 8'h00, card_select_number);
    $display("test reset done");
    send_key();
    chk("state", {4'h0, IPCC_SLEEP}, {4'h0, card_state});
    rw(IPCC_IDX_WAKE, 8'h00);
    chk("state", {4'h0, IPCC_ISOLATE}, {4'h0, card_state});
    rw(IPCC_IDX_RD_PORT, 8'h80);
    rport = 12'h203;
    host_u.wr(IPCC_INDEX_PORT, IPCC_IDX_ISOLATE);
    // Own one answers 55h then AAh, own zero leaves the pull-ups
    for (int i = 0; i < 8; i++) begin
      host_u.rd(rport, v);
      chk("iso first", SER[i] ? IPCC_ISO_FIRST : 8'hff, v);
      host_u.rd(rport, v);
      chk("iso second", SER[i] ? IPCC_ISO_SECOND : 8'hff, v);
    end
    // Another card shows a one where this card has a zero: this card drops out
    host_u.set_other(IPCC_ISO_FIRST);
    host_u.rd(rport, v);
    chk("iso other first", IPCC_ISO_FIRST, v);
    host_u.set_other(IPCC_ISO_SECOND);
    host_u.rd(rport, v);
    host_u.set_other(8'hff);
    chk("iso other second", IPCC_ISO_SECOND, v);
    chk("state", {4'h0, IPCC_SLEEP}, {4'h0, card_state});
    rw(IPCC_IDX_WAKE, 8'h00);
    chk("state", {4'h0, IPCC_ISOLATE}, {4'h0, card_state});
    host_u.rd(12'h003, v);
    chk("old port", 8'hff, v);
    rw(IPCC_IDX_CSN, 8'h07);
    chk("state", {4'h0, IPCC_CONFIG}, {4'h0, card_state});
    rr(IPCC_IDX_CSN, v);
    chk("csn", 8'h07, v);
    rr(IPCC_IDX_LDEV, v);
    chk("ldev", 8'h00, v);
    rr(8'h09, v);
    chk("undef", 8'h00, v);
    $display("test isolation done");
    for (int i = 0; i < 5; i++) begin
      rd_res(v);
      chk("resource", RES[8*(i%4) +: 8], v);
    end
    $display("test resource done");
    p0 = pulses;
    rw(IPCC_IDX_CONFIG, 8'h01);
    chk("pulses", 8'h01, 8'(pulses - p0));
    chk("csn", 8'h07, card_select_number);
    rd_res(v);
    chk("resource", RES[7:0], v);
    rw(IPCC_IDX_CONFIG, 8'h02);
    chk("state", {4'h0, IPCC_WAIT_KEY}, {4'h0, card_state});
    chk("csn", 8'h07, card_select_number);
    host_u.rd(rport, v);
    chk("no drive", 8'hff, v);
    send_key();
    rw(IPCC_IDX_WAKE, 8'h05);
    chk("state", {4'h0, IPCC_SLEEP}, {4'h0, card_state});
    rw(IPCC_IDX_WAKE, 8'h07);
    chk("state", {4'h0, IPCC_CONFIG}, {4'h0, card_state});
    rw(IPCC_IDX_CONFIG, 8'h04);
    chk("csn", 8'h00, card_select_number);
    chk("state", {4'h0, IPCC_CONFIG}, {4'h0, card_state});
    chk("pulses", 8'h01, 8'(pulses - p0));
    $display("test commands done");
    // Reset in mid-run: card number and state return to their reset values
    rw(IPCC_IDX_CSN, 8'h09);
    chk("csn", 8'h09, card_select_number);
    reset_n = 1'b0;
    host_u.tick(4);
    reset_n = 1'b1;
    host_u.tick(1);
    chk("state", {4'h0, IPCC_WAIT_KEY}, {4'h0, card_state});
    chk("csn", 8'h00, card_select_number);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
